// ---- rtl/fvg_gateway.sv ----
`timescale 1ns/10ps
module fvg_gateway
	import fvg_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES
)(
	// clock, reset, enable
	input  wire logic                         mclk_in,
	input  wire logic                         rst_n_in,
	input  wire logic                         ce_in,
	// configuration switches, on = 1
	input  wire logic [3:0]                   node_addr_tens_switch_in,
	input  wire logic [3:0]                   node_addr_ones_switch_in,
	input  wire logic [1:0]                   fieldbus_rate_switch_in,
	input  wire logic [3:0]                   link_mode_switch_in,
	// decoded configuration
	output logic [5:0]                        node_addr_out,
	output fvg_fb_rate_t                      fb_rate_out,
	output logic                              link_rate_250_out,
	output logic                              assembly_test_out,
	// fieldbus slave side
	input  wire logic                         fb_online_in,
	input  wire logic                         fb_allocated_in,
	input  wire logic                         fb_io_active_in,
	input  wire logic                         fb_pkt_timeout_in,
	input  wire logic                         fb_power_lost_in,
	input  wire logic                         fb_major_err_in,
	input  wire logic                         fb_out_wr_in,
	input  wire logic [3:0]                   fb_out_idx_in,
	input  wire logic [7:0]                   fb_out_data_in,
	input  wire logic [5:0]                   fb_in_idx_in,
	output logic [7:0]                        fb_in_data_out,
	input  wire logic                         param_req_in,
	output logic                              param_reject_out,
	// valve link side
	input  wire logic [3:0]                   link_out_idx_in,
	output logic [7:0]                        link_out_data_out,
	input  wire logic                         link_in_wr_in,
	input  wire logic                         link_in_is_diag_in,
	input  wire logic [5:0]                   link_in_idx_in,
	input  wire logic [7:0]                   link_in_data_in,
	output logic                              disc_start_out,
	input  wire logic                         disc_done_in,
	input  wire logic [LINK_ADDRS-1:0]        disc_present_in,
	input  wire logic [5:0]                   disc_in_len_in,
	input  wire logic [5:0]                   disc_diag_len_in,
	input  wire logic [LINK_ADDRS*TYPE_W-1:0] disc_types_in,
	input  wire logic                         disc_addr_err_in,
	// supply monitoring, millivolt readings at the link output port and of the own electronics supply
	input  wire logic [15:0]                  link_sens_mv_in,
	input  wire logic [15:0]                  link_valve_mv_in,
	input  wire logic [15:0]                  own_elec_mv_in,
	input  wire logic                         sens_short_in,
	input  wire logic                         valve_short_in,
	// leds, 1 = lit
	output logic                              supply_led_out,
	output logic                              status_led_out,
	output logic                              network_state_led_red_out,
	output logic                              run_led_green_out
);
	localparam int unsigned TW = LINK_ADDRS * TYPE_W;

	typedef struct packed {
		fvg_state_t                 st;
		logic [5:0]                 node_addr;
		fvg_fb_rate_t               fb_rate;
		logic                       link_250;
		logic                       asm_test;
		logic [OUT_MAX-1:0][7:0]    out_img;
		logic [PART_MAX-1:0][7:0]   in_img;
		logic [LINK_ADDRS-1:0]      ref_pres;
		logic [LINK_ADDRS-1:0]      cur_pres;
		logic [4:0]                 ref_in;
		logic [4:0]                 cur_in;
		logic [5:0]                 ref_dg;
		logic [5:0]                 cur_dg;
		logic [TW-1:0]              ref_ty;
		logic                       addr_err;
		logic                       cfg_chg;
		logic                       disc_seen;
		logic [TMR_W-1:0]           wait_ms;
		logic [TMR_W-1:0]           zero_ms;
		logic                       disc_start;
		logic [7:0]                 link_data;
		logic [7:0]                 fb_data;
		logic                       sup_led;
		logic                       sta_led;
		logic                       net_red;
		logic                       run_grn;
	} fvg_gw_st_t;

	fvg_gw_st_t q, d;
	logic       tick_ms;
	logic       b1;
	logic       b2;
	logic       hb;

	// ----------------------------------------
	// time bases
	// ----------------------------------------
	fvg_blink #(
		.MS_CYC (MS_CYC)
	) u_blink (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n_in),
		.ce_in         (ce_in),
		.tick_ms_out   (tick_ms),
		.blink_1hz_out (b1),
		.blink_2hz_out (b2),
		.heart_out     (hb)
	);

	// ----------------------------------------
	// switch decode and discovery summary
	// ----------------------------------------
	logic [7:0]       sw_sum;
	logic [5:0]       addr_calc;
	fvg_fb_rate_t     rate_calc;
	logic [4:0]       in_cl;
	logic [5:0]       dg_cl;
	logic [5:0]       dg_room;
	logic             mismatch;
	logic             contig;
	logic             sens_bad;
	logic             valve_bad;
	logic             own_bad;
	logic             cfg_ok;
	logic             cfg_bad;
	logic [6:0]       total_len;
	logic [7:0]       diag0;
	logic [7:0]       diag1;
	logic [7:0]       diag2;
	logic [7:0]       diag3;
	logic [5:0]       part_idx;

	assign sw_sum    = 8'(node_addr_tens_switch_in) * 8'(TENS_MUL)
	                 + 8'(node_addr_ones_switch_in);
	assign addr_calc = (sw_sum > 8'(ADDR_LIMIT)) ? 6'(sw_sum - 8'(ADDR_SPAN))
	                 : sw_sum[5:0];
	// both bits on is not a listed setting, so it falls back to the default
	always_comb
	begin
		unique case ({fieldbus_rate_switch_in[SW_BIT2], fieldbus_rate_switch_in[SW_BIT1]})
			2'b01:   rate_calc = FVG_FB_500;
			2'b00:   rate_calc = FVG_FB_125;
			default: rate_calc = FVG_FB_250;
		endcase
	end

	// lengths clamped so the input image never passes its fifty bytes
	assign in_cl   = (disc_in_len_in > 6'(IN_MAX)) ? 5'(IN_MAX) : disc_in_len_in[4:0];
	assign dg_room = 6'(PART_MAX) - 6'(in_cl);
	assign dg_cl   = (disc_diag_len_in > dg_room) ? dg_room : disc_diag_len_in;
	assign mismatch = (disc_present_in != q.ref_pres) || (in_cl != q.ref_in)
	               || (dg_cl != q.ref_dg) || (disc_types_in != q.ref_ty);
	// participants are expected to fill addresses upward from one
	assign contig  = ((q.cur_pres + LINK_ADDRS'(1)) & q.cur_pres) == '0;

	assign sens_bad  = (link_sens_mv_in < 16'(ELEC_MIN_MV))
	                || (link_sens_mv_in > 16'(ELEC_MAX_MV));
	assign valve_bad = (link_valve_mv_in < 16'(VALVE_MIN_MV))
	                || (link_valve_mv_in > 16'(VALVE_MAX_MV));
	assign own_bad   = (own_elec_mv_in < 16'(ELEC_MIN_MV))
	                || (own_elec_mv_in > 16'(ELEC_MAX_MV));

	assign cfg_ok  = q.disc_seen && (q.cur_pres != '0) && !q.addr_err && !q.cfg_chg;
	assign cfg_bad = q.disc_seen && !cfg_ok;

	// ----------------------------------------
	// diagnosis header
	// ----------------------------------------
	assign total_len = 7'(OWN_DIAG) + 7'(q.cur_in) + 7'(q.cur_dg);
	always_comb
	begin
		diag0                  = 8'h00;
		diag0[DIAG_LINK_ELEC]  = sens_bad;
		diag0[DIAG_LINK_VALVE] = valve_bad;
		diag0[DIAG_OWN_ELEC]   = own_bad;
		diag0[DIAG_NO_PART]    = q.disc_seen && (q.cur_pres == '0);
		diag0[DIAG_ADDR_ERR]   = q.addr_err;
		diag0[DIAG_CFG_CHG]    = q.cfg_chg;
		diag1                  = {1'b0, total_len};
		diag1[DIAG_HEART]      = hb;
		diag2                  = q.cur_pres[7:0];
		diag3                  = {2'b00, q.cur_pres[LINK_ADDRS-1:8]};
	end
	assign part_idx = fb_in_idx_in - 6'(OWN_DIAG);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.disc_start = 1'b0;
		// output image writes; the 4-bit index cannot reach past sixteen bytes
		if (fb_out_wr_in)
			d.out_img[fb_out_idx_in] = fb_out_data_in;
		// link data lands in its fixed place: inputs first, then diagnosis
		if (link_in_wr_in)
		begin
			if (!link_in_is_diag_in && (link_in_idx_in < 6'(q.cur_in)))
				d.in_img[link_in_idx_in] = link_in_data_in;
			else if (link_in_is_diag_in && (link_in_idx_in < q.cur_dg))
				d.in_img[6'(q.cur_in) + link_in_idx_in] = link_in_data_in;
		end
		// zero-image timer runs in every state, rechecks only act in run
		if (q.out_img != '0)
			d.zero_ms = '0;
		else if (tick_ms && (q.zero_ms != TMR_W'(ZERO_HOLD_MS)))
			d.zero_ms = q.zero_ms + TMR_W'(1);
		if (disc_done_in && (q.st != FVG_BOOT) && (q.st != FVG_WAIT) && (q.st != FVG_RUN))
		begin
			d.cur_pres  = disc_present_in;
			d.cur_in    = in_cl;
			d.cur_dg    = dg_cl;
			d.addr_err  = disc_addr_err_in;
			d.disc_seen = 1'b1;
		end
		if (q.disc_seen && q.cur_pres != '0 && !contig)
			d.addr_err = 1'b1;
		unique case (q.st)
			FVG_BOOT:
			begin
				// switches are caught once; later moves wait for a power cycle
				d.node_addr  = addr_calc;
				d.fb_rate    = rate_calc;
				d.link_250   = link_mode_switch_in[SW_BIT1];
				d.asm_test   = link_mode_switch_in[SW_BIT2];
				d.disc_start = 1'b1;
				d.st         = FVG_DISC1;
			end
			FVG_DISC1:
			begin
				if (disc_done_in)
				begin
					d.ref_pres = disc_present_in;
					d.ref_in   = in_cl;
					d.ref_dg   = dg_cl;
					d.ref_ty   = disc_types_in;
					d.wait_ms  = '0;
					d.st       = FVG_WAIT;
				end
			end
			FVG_WAIT:
			begin
				if (tick_ms)
				begin
					d.wait_ms = q.wait_ms + TMR_W'(1);
					if (q.wait_ms == TMR_W'(RECHECK_MS - 1))
					begin
						d.disc_start = 1'b1;
						d.st         = FVG_DISC2;
					end
				end
			end
			FVG_DISC2, FVG_DISCZ:
			begin
				if (disc_done_in)
				begin
					if (mismatch)
						d.cfg_chg = 1'b1;
					d.zero_ms = '0;
					d.st      = FVG_RUN;
				end
			end
			FVG_RUN:
			begin
				// data paths keep running while the recheck is under way
				if (q.zero_ms == TMR_W'(ZERO_HOLD_MS))
				begin
					d.disc_start = 1'b1;
					d.zero_ms    = '0;
					d.st         = FVG_DISCZ;
				end
			end
			default: d.st = FVG_BOOT;
		endcase
		// forwarded output bytes drop to zero on the clock after the fieldbus is lost
		d.link_data = fb_online_in ? q.out_img[link_out_idx_in] : 8'h00;
		// own header, then participant area, zero past the image length
		if (fb_in_idx_in == 6'd0)
			d.fb_data = diag0;
		else if (fb_in_idx_in == 6'd1)
			d.fb_data = diag1;
		else if (fb_in_idx_in == 6'd2)
			d.fb_data = diag2;
		else if (fb_in_idx_in == 6'd3)
			d.fb_data = diag3;
		else if (7'(part_idx) < (total_len - 7'(OWN_DIAG)))
			d.fb_data = q.in_img[part_idx];
		else
			d.fb_data = 8'h00;
		// a bad configuration outranks supply faults on the shared leds
		d.sup_led = cfg_bad ? b2
		          : (sens_bad || sens_short_in) ? b1
		          : (cfg_ok && !valve_bad);
		d.sta_led = cfg_bad ? b2
		          : (valve_bad || valve_short_in) ? b1
		          : (cfg_ok && !sens_bad);
		d.net_red = fb_major_err_in || (fb_pkt_timeout_in && b1);
		d.run_grn = !fb_major_err_in && !fb_pkt_timeout_in
		          && (fb_power_lost_in ? b1 : (fb_allocated_in && fb_io_active_in));
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			q <= '0;
		else if (ce_in)
			q <= d;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign node_addr_out             = q.node_addr;
	assign fb_rate_out               = q.fb_rate;
	assign link_rate_250_out         = q.link_250;
	assign assembly_test_out         = q.asm_test;
	assign fb_in_data_out            = q.fb_data;
	assign link_out_data_out         = q.link_data;
	assign disc_start_out            = q.disc_start;
	assign param_reject_out          = param_req_in;
	assign supply_led_out            = q.sup_led;
	assign status_led_out            = q.sta_led;
	assign network_state_led_red_out = q.net_red;
	assign run_led_green_out         = q.run_grn;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	node_addr_a: assert property (q.st == FVG_BOOT && ce_in |=> node_addr_out == $past(addr_calc))
		else $error("node address not taken from switches");
	addr_range_a: assert property (sw_sum > 8'(ADDR_LIMIT) && sw_sum < 8'd128 |-> {2'b01, addr_calc} == sw_sum)
		else $error("node address out of range");
	fb_rate_a: assert property (q.st == FVG_BOOT && ce_in && fieldbus_rate_switch_in == 2'b01
		|=> fb_rate_out == FVG_FB_500)
		else $error("fieldbus rate decode wrong");
	link_zero_a: assert property (!fb_online_in && ce_in |=> link_out_data_out == 8'h00)
		else $error("output forwarded while fieldbus lost");
	img_len_a: assert property (total_len <= 7'(IMG_MAX))
		else $error("input image longer than fifty bytes");
	recheck_a: assert property (q.st == FVG_WAIT && ce_in && tick_ms
		&& q.wait_ms == TMR_W'(RECHECK_MS - 1) |=> disc_start_out ##1 q.st == FVG_DISC2)
		else $error("second discovery not started");
	cfg_chg_a: assert property (q.st == FVG_DISC2 && ce_in && disc_done_in && mismatch
		|=> diag0[DIAG_CFG_CHG])
		else $error("configuration change not flagged");
	zero_recheck_a: assert property (q.st == FVG_RUN && ce_in && q.zero_ms == TMR_W'(ZERO_HOLD_MS)
		|=> q.st == FVG_DISCZ && disc_start_out)
		else $error("zero image recheck missing");
	cfg_led_a: assert property (cfg_bad && ce_in |=> supply_led_out == $past(b2)
		&& status_led_out == $past(b2))
		else $error("invalid configuration flash wrong");
	no_param_a: assert property (param_req_in |-> param_reject_out)
		else $error("parameter download accepted");
	diag_head_a: assert property (fb_in_idx_in == 6'd0 && ce_in |=> fb_in_data_out == $past(diag0))
		else $error("diagnosis byte 0 not first");

	mismatch_c: cover property (q.st == FVG_DISC2 && disc_done_in && mismatch);
	zero_c:     cover property (q.st == FVG_DISCZ);
	led_ok_c:   cover property (cfg_ok && supply_led_out && status_led_out);
	major_c:    cover property (network_state_led_red_out && fb_major_err_in);
endmodule

// ---- rtl/fvg_pkg.sv ----
package fvg_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ       = 250_000_000;
	localparam int unsigned MS_PER_S     = 1000;
	localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S;
	localparam int unsigned RECHECK_MS   = 5000;
	localparam int unsigned ZERO_HOLD_MS = 5000;
	localparam int unsigned HEART_MS     = 2500;
	localparam int unsigned BLINK_1HZ_MS = MS_PER_S / 2;
	localparam int unsigned BLINK_2HZ_MS = MS_PER_S / 4;
	localparam int unsigned TMR_W        = 13;
	// ----------------------------------------
	// images and addressing
	// ----------------------------------------
	localparam int unsigned OUT_MAX    = 16;
	localparam int unsigned IN_MAX     = 16;
	localparam int unsigned IMG_MAX    = 50;
	localparam int unsigned OWN_DIAG   = 4;
	localparam int unsigned PART_MAX   = IMG_MAX - OWN_DIAG;
	localparam int unsigned LINK_ADDRS = 14;
	localparam int unsigned TYPE_W     = 2;
	localparam int unsigned ADDR_LIMIT = 63;
	localparam int unsigned ADDR_SPAN  = 64;
	localparam int unsigned TENS_MUL   = 10;
	// ----------------------------------------
	// supply limits in millivolt
	// ----------------------------------------
	localparam int unsigned VALVE_MIN_MV = 21600;
	localparam int unsigned VALVE_MAX_MV = 26400;
	localparam int unsigned ELEC_MIN_MV  = 19200;
	localparam int unsigned ELEC_MAX_MV  = 28800;
	// ----------------------------------------
	// switch bits and diagnosis bit positions
	// ----------------------------------------
	localparam int unsigned SW_BIT1         = 0;
	localparam int unsigned SW_BIT2         = 1;
	localparam int unsigned DIAG_LINK_ELEC  = 0;
	localparam int unsigned DIAG_LINK_VALVE = 1;
	localparam int unsigned DIAG_OWN_ELEC   = 2;
	localparam int unsigned DIAG_NO_PART    = 3;
	localparam int unsigned DIAG_ADDR_ERR   = 4;
	localparam int unsigned DIAG_CFG_CHG    = 5;
	localparam int unsigned DIAG_HEART      = 7;

	typedef enum logic [1:0] {
		FVG_FB_125 = 2'b00,
		FVG_FB_250 = 2'b01,
		FVG_FB_500 = 2'b10
	} fvg_fb_rate_t;

	typedef enum logic [2:0] {
		FVG_BOOT  = 3'b000,
		FVG_DISC1 = 3'b001,
		FVG_WAIT  = 3'b010,
		FVG_DISC2 = 3'b011,
		FVG_RUN   = 3'b100,
		FVG_DISCZ = 3'b101
	} fvg_state_t;
endpackage

// ---- rtl/fvg_blink.sv ----
`timescale 1ns/10ps
module fvg_blink
	import fvg_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES
)(
	// clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	input  wire logic ce_in,
	// time bases
	output logic      tick_ms_out,
	output logic      blink_1hz_out,
	output logic      blink_2hz_out,
	output logic      heart_out
);
	localparam int unsigned PW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

	typedef struct packed {
		logic [PW-1:0]    pre;
		logic             tick;
		logic [TMR_W-1:0] c1;
		logic [TMR_W-1:0] c2;
		logic [TMR_W-1:0] ch;
		logic             b1;
		logic             b2;
		logic             hb;
	} fvg_blink_st_t;

	fvg_blink_st_t q, d;

	// ----------------------------------------
	// millisecond prescaler and phase counters
	// ----------------------------------------
	// one shared ms tick keeps all flash phases coherent across leds
	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		if (q.pre == PW'(MS_CYC - 1))
		begin
			d.pre  = '0;
			d.tick = 1'b1;
		end
		else
			d.pre = q.pre + PW'(1);
		if (q.tick)
		begin
			d.c1 = (q.c1 == TMR_W'(BLINK_1HZ_MS - 1)) ? '0 : q.c1 + TMR_W'(1);
			d.c2 = (q.c2 == TMR_W'(BLINK_2HZ_MS - 1)) ? '0 : q.c2 + TMR_W'(1);
			d.ch = (q.ch == TMR_W'(HEART_MS - 1)) ? '0 : q.ch + TMR_W'(1);
			if (q.c1 == TMR_W'(BLINK_1HZ_MS - 1))
				d.b1 = ~q.b1;
			if (q.c2 == TMR_W'(BLINK_2HZ_MS - 1))
				d.b2 = ~q.b2;
			if (q.ch == TMR_W'(HEART_MS - 1))
				d.hb = ~q.hb;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
			q <= '0;
		else if (ce_in)
			q <= d;
	end

	assign tick_ms_out   = q.tick;
	assign blink_1hz_out = q.b1;
	assign blink_2hz_out = q.b2;
	assign heart_out     = q.hb;
endmodule

// ---- tb/fvg_link_model.sv ----
`timescale 1ns/10ps
module fvg_link_model
	import fvg_pkg::*;
(
	// clock and request
	input  wire logic                    mclk_in,
	input  wire logic                    start_in,
	input  wire logic                    alt_in,
	input  wire logic [3:0]              lat_in,
	// discovery result
	output logic                         done_out,
	output logic [LINK_ADDRS-1:0]        present_out,
	output logic [5:0]                   in_len_out,
	output logic [5:0]                   diag_len_out,
	output logic [LINK_ADDRS*TYPE_W-1:0] types_out,
	output logic                         addr_err_out,
	output int                           dones_out
);
	logic [LINK_ADDRS-1:0] map;
	// results only hold with done, so the lines carry the inverse in between
	initial
	begin
		dones_out = 0;
		done_out = 1'b0;
		forever
		begin
			map = alt_in ? 14'h000f : 14'h0007;
			{present_out, in_len_out, diag_len_out} = ~{map, 6'h02, 6'h03};
			types_out = ~{LINK_ADDRS{2'b01}};
			addr_err_out = 1'b1;
			@(posedge mclk_in);
			if (start_in === 1'b1)
			begin
				repeat (lat_in) @(posedge mclk_in);
				#1;
				done_out = 1'b1;
				{present_out, in_len_out, diag_len_out} = {map, 6'h02, 6'h03};
				types_out = {LINK_ADDRS{2'b01}};
				addr_err_out = 1'b0;
				dones_out++;
				@(posedge mclk_in);
				#1;
				done_out = 1'b0;
			end
		end
	end
endmodule

// ---- tb/fvg_gateway_tb_top.sv ----
`timescale 1ns/10ps
module fvg_gateway_tb_top;
	import fvg_pkg::*;
	localparam int unsigned TB_MS = 4;
	logic        mclk_in, rst_n_in, online, owr, preq, iwr, isd, alt;
	logic        sshort, vshort, sled, tled, nred, rgrn;
	logic [3:0]  tens, ones, lsw, oidx, lidx, lat;
	logic [1:0]  rsw;
	logic [4:0]  fbs;
	logic [5:0]  iidx, widx, naddr, ilen, dlen;
	logic [7:0]  odat, wdat, indat, lodat, e;
	logic        l250, atest, rej, dst, ddone, aerr;
	logic [15:0] mv, vmv;
	logic [13:0] pres;
	logic [27:0] typ;
	fvg_fb_rate_t rate;
	int          dones, errors, checks, base;
	fvg_gateway #(.MS_CYC(TB_MS)) fvg_gateway_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.ce_in(1'b1), .node_addr_tens_switch_in(tens), .node_addr_ones_switch_in(ones),
		.fieldbus_rate_switch_in(rsw), .link_mode_switch_in(lsw), .node_addr_out(naddr),
		.fb_rate_out(rate), .link_rate_250_out(l250), .assembly_test_out(atest),
		.fb_online_in(online), .fb_allocated_in(fbs[0]), .fb_io_active_in(fbs[1]),
		.fb_pkt_timeout_in(fbs[2]), .fb_power_lost_in(fbs[3]), .fb_major_err_in(fbs[4]),
		.fb_out_wr_in(owr), .fb_out_idx_in(oidx), .fb_out_data_in(odat), .fb_in_idx_in(iidx),
		.fb_in_data_out(indat), .param_req_in(preq), .param_reject_out(rej),
		.link_out_idx_in(lidx), .link_out_data_out(lodat), .link_in_wr_in(iwr),
		.link_in_is_diag_in(isd), .link_in_idx_in(widx), .link_in_data_in(wdat),
		.disc_start_out(dst), .disc_done_in(ddone), .disc_present_in(pres),
		.disc_in_len_in(ilen), .disc_diag_len_in(dlen), .disc_types_in(typ),
		.disc_addr_err_in(aerr), .link_sens_mv_in(mv), .link_valve_mv_in(vmv),
		.own_elec_mv_in(mv), .sens_short_in(sshort), .valve_short_in(vshort),
		.supply_led_out(sled), .status_led_out(tled), .network_state_led_red_out(nred),
		.run_led_green_out(rgrn));
	fvg_link_model fvg_link_model_i (.mclk_in(mclk_in), .start_in(dst), .alt_in(alt),
		.lat_in(lat), .done_out(ddone), .present_out(pres), .in_len_out(ilen),
		.diag_len_out(dlen), .types_out(typ), .addr_err_out(aerr), .dones_out(dones));
	// free-running 250 MHz clock
	initial
	begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		checks++;
		if (got !== ex)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// read flop answers one cycle after the index is presented
	task automatic rd(input logic [5:0] i, input logic [7:0] m, input logic [7:0] ex);
		iidx = i;
		step(1);
		chk("input image byte", ex, indat & m);
	endtask
	task automatic lo(input logic [3:0] i, input logic [7:0] ex);
		lidx = i;
		step(1);
		chk("link output byte", ex, lodat);
	endtask
	// strobe stays up between back-to-back writes; the caller drops it
	task automatic ow(input logic [3:0] i, input logic [7:0] d);
		{owr, oidx, odat} = {1'b1, i, d};
		step(1);
	endtask
	// changes of both green leds over one 1 hz period: 2 at 1 hz, 4 at 2 hz, 0 steady
	task automatic blinks(input int es, input int et);
		int   ns;
		int   nt;
		logic ps;
		logic pt;
		ns = 0;
		nt = 0;
		ps = sled;
		pt = tled;
		repeat (2 * BLINK_1HZ_MS * TB_MS)
		begin
			step(1);
			ns += (sled != ps) ? 1 : 0;
			nt += (tled != pt) ? 1 : 0;
			ps = sled;
			pt = tled;
		end
		chk("supply led changes", 8'(es), 8'(ns));
		chk("status led changes", 8'(et), 8'(nt));
	endtask
	task automatic wr(input logic dg, input logic [5:0] i, input logic [7:0] d);
		{iwr, isd, widx, wdat} = {1'b1, dg, i, d};
		step(1);
	endtask
	// bounded wait for the n-th discovery answer
	task automatic waitd(input int n);
		int k;
		for (k = 0; k < 30000 && dones < n; k++)
			step(1);
		if (dones < n)
		begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic boot();
		rst_n_in = 1'b0;
		step(8);
		rst_n_in = 1'b1;
		step(3);
	endtask
	function automatic logic [7:0] addr_exp(input logic [3:0] t, input logic [3:0] o);
		int v;
		v = t * 10 + o;
		return (v > 63) ? 8'(v - 64) : 8'(v);
	endfunction
	function automatic logic [7:0] rate_exp(input logic [1:0] s);
		return (s == 2'b01) ? 8'h02 : ((s == 2'b00) ? 8'h00 : 8'h01);
	endfunction
	initial
	begin
		{rst_n_in, online, owr, preq, iwr, isd, alt, oidx, lidx, widx, wdat, odat} = '0;
		{tens, ones, rsw, lsw, iidx, lat, fbs} = '0;
		mv = 16'h5dc0;
		vmv = mv;
		{sshort, vshort} = 2'b00;
		void'($urandom(32'h491c));
		fbs = 5'($urandom);
		// switch sampling, one power-up per rate code
		for (int r = 0; r < 4; r++)
		begin
			{tens, ones, rsw, lsw} = {4'($urandom_range(9)), 4'($urandom_range(9)), 2'(r), 4'($urandom)};
			lat = 4'($urandom_range(8, 1));
			boot();
			e = addr_exp(tens, ones);
			chk("node address", e, {2'h0, naddr});
			chk("fieldbus rate", rate_exp(rsw), {6'h0, rate});
			chk("link mode", {6'h0, lsw[1:0]}, {6'h0, atest, l250});
			tens = tens ^ 4'h1;
			step(2);
			chk("held address", e, {2'h0, naddr});
		end
		boot();
		base = dones;
		waitd(base + 1);
		step(1);
		rd(6'h00, 8'hff, 8'h00);
		rd(6'h01, 8'h7f, 8'h09);
		rd(6'h02, 8'hff, 8'h07);
		rd(6'h03, 8'hff, 8'h00);
		// input 0, refused input 2, diag 2, back to back
		wr(1'b0, 6'h00, 8'h5a);
		wr(1'b0, 6'h02, 8'hee);
		wr(1'b1, 6'h02, 8'hc3);
		iwr = 1'b0;
		rd(6'h04, 8'hff, 8'h5a);
		rd(6'h06, 8'hff, 8'h00);
		rd(6'h08, 8'hff, 8'hc3);
		rd(6'h09, 8'hff, 8'h00);
		online = 1'b1;
		e = 8'($urandom);
		ow(4'h3, 8'haa);
		ow(4'hf, e);
		owr = 1'b0;
		lo(4'hf, e);
		lo(4'h3, 8'haa);
		online = 1'b1;
		lo(4'h3, 8'haa);
		online = 1'b0;
		lo(4'h3, 8'h00);
		online = 1'b1;
		preq = 1'b1;
		#1;
		chk("parameter refusal", 8'h01, {7'h0, rej});
		preq = 1'b0;
		// led encodings while configuration and supplies are good
		fbs = 5'h03;
		step(1);
		chk("network leds", 8'h01, {6'h0, nred, rgrn});
		fbs = 5'h10;
		step(1);
		chk("network leds", 8'h02, {6'h0, nred, rgrn});
		chk("green leds", 8'h03, {6'h0, sled, tled});
		// valve supply above its window, then each short on its own
		vmv = 16'(VALVE_MAX_MV + 1 + $urandom_range(999));
		step(2);
		rd(6'h00, 8'hff, 8'h02);
		blinks(0, 2);
		vmv = mv;
		sshort = 1'b1;
		step(2);
		blinks(2, 0);
		{sshort, vshort} = 2'b01;
		step(2);
		blinks(0, 2);
		vshort = 1'b0;
		alt = 1'b1;
		waitd(base + 2);
		step(1);
		rd(6'h00, 8'hff, 8'h20);
		rd(6'h02, 8'hff, 8'h0f);
		blinks(4, 4);
		ow(4'h3, 8'h00);
		ow(4'hf, 8'h00);
		owr = 1'b0;
		waitd(base + 3);
		step(1);
		rd(6'h04, 8'hff, 8'h5a);
		print_verdict();
	end
endmodule
